// file: dar_pkg.sv
// Shared constants and types for the dual converter serial readout block.
// Overview of operation
// - Two-line auto mode steps input pairs, ignores input_select, A on out_a, B on out_b.
// - Two-line frame is pair bit, a zero, then result MSB first, zero padded.
// - Pseudo-differential lets the sequencer drive the mux in auto modes and forces channel info off.
// - Buffer usable in two-line auto and special modes; one strobe drains it; host fills first.
// - Single-line auto sends all on out_a; out_b floats after the next conversion.
// - Single-line frame is pair bit, converter bit, result, then trailing zeros.
// - Single-line mode offers no full clock, and the buffer only in special read; pseudo order from sequencer.
// - Single-line mode applies buffer, special, pseudo, info bits one read late.
// - Special read shifts both results on out_a for one strobe, twenty clocks apart.
// - Special read with auto-sleep sends each result during the following conversion.
// - Reference write is a setup frame selecting it, then a frame with the level.
// - Reference readback selected by setup frame appears on out_a at next strobe.
// - Readback frame is value and four zeros, or two indicator bits, value, two zeros.
// - Readback drops the A result, keeps B on out_b except when it waits behind a buffer drain, ignores serial input.
// - Both reference levels reset to 7FFh.
// - Register words are 16 bits, MSB first, framed by the read strobe.
// - A register update takes effect right after its sixteenth input bit.
// - Setup register takes one write; others need a selecting setup write first.
// - A setup write sent with a readback request is ignored.
// - Update code 01 writes all of setup; 00 and 11 only input_select when low mode is 0.
// - Setup bit 8 enables the special single-pulse read; reset leaves it off.
// - Setup bit 5 set removes channel indicator bits from every frame.
// - Access code 0100 is a software reset; codes 0000, 0111, 1000, 1111 select nothing, others a register access.
package dar_pkg;
    localparam int WORD_BITS  = 16;
    localparam int FRAME_BITS = 20;
    localparam int PAIR_BITS  = 40;
    localparam int CFG_C      = 14;
    localparam int CFG_R      = 12;
    localparam int CFG_PD     = 10;
    localparam int CFG_FE     = 9;
    localparam int CFG_SR     = 8;
    localparam int CFG_FC     = 7;
    localparam int CFG_PDE    = 6;
    localparam int CFG_CID    = 5;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] REF_RESET = 16'h07ff;
    localparam logic [15:0] REF_MASK  = 16'h07ff;
    localparam logic [15:0] SEQ_RESET = 16'h0000;
    localparam logic [15:0] CM_RESET  = 16'h0000;
    localparam logic [1:0]  UPD_WHOLE = 2'h1;
    localparam logic [1:0]  UPD_SEL_A = 2'h0;
    localparam logic [1:0]  UPD_SEL_B = 2'h3;
    localparam logic [1:0]  PD_AUTO   = 2'h3;
    localparam logic [3:0]  ACC_RD_CFG = 4'h1;
    localparam logic [2:0]  ACC_WR_REF1 = 3'h2;
    localparam logic [3:0]  ACC_RD_REF1 = 4'h3;
    localparam logic [3:0]  ACC_SWRST  = 4'h4;
    localparam logic [2:0]  ACC_WR_REF2 = 3'h5;
    localparam logic [3:0]  ACC_RD_REF2 = 4'h6;
    localparam logic [3:0]  ACC_WR_SEQ = 4'h9;
    localparam logic [3:0]  ACC_RD_SEQ = 4'hb;
    localparam logic [3:0]  ACC_WR_CM  = 4'hc;
    localparam logic [3:0]  ACC_RD_CM  = 4'he;

    typedef enum logic [2:0] {
        DAR_TGT_NONE,
        DAR_TGT_CFG,
        DAR_TGT_REF1,
        DAR_TGT_REF2,
        DAR_TGT_SEQ,
        DAR_TGT_CM
    } dar_tgt_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] a;
        logic [15:0] b;
    } dar_result_t;

    typedef struct packed {
        logic        ch;
        logic [15:0] a;
        logic [15:0] b;
    } dar_word_t;
endpackage

// file: dar_serial_regs.sv
// Serial register port, readout framing and result buffer of the converter.
`timescale 1ns/1ns
`default_nettype none

module dar_fifo #(
    parameter int W = 33,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
        $error("dar_fifo depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
        logic                rdy;
    } dar_fifo_st_t;

    dar_fifo_st_t st;
    dar_fifo_st_t next_st;
    logic         push;
    logic         pop;

    assign out_valid = st.cnt != '0;
    assign out_data  = st.mem[st.rp];
    assign in_ready  = st.rdy;

    always_comb begin
        next_st = st;
        push = in_valid && st.rdy;
        pop  = out_ready && out_valid;
        if (push) begin
            next_st.mem[st.wp] = in_data;
            next_st.wp = st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
        // Ready is registered so the source sees back-pressure from a flop.
        next_st.rdy = next_st.cnt != (AW+1)'(D);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.rdy <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
endmodule

module dar_serial_regs
    import dar_pkg::*;
#(
    parameter int RES_BITS   = 16,
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              conversion_trigger,
    input  wire logic              read_strobe,
    input  wire logic              serial_in,
    input  wire logic              mode_select_low,
    input  wire logic              mode_select_high,
    input  wire dar_pkg::dar_result_t result,
    output logic                   result_ready,
    output logic                   conv_start,
    output logic [1:0]             mux_select,
    output logic                   serial_out_a,
    output logic                   serial_out_b,
    output logic                   serial_out_b_oe_n,
    output logic [15:0]            reference_level_one,
    output logic [15:0]            reference_level_two,
    output logic [1:0]             power_mode
);
    import dar_pkg::*;

    if (RES_BITS != 16 && RES_BITS != 14 && RES_BITS != 12) begin : g_chk
        $error("dar_serial_regs resolution must be 12, 14 or 16");
    end

    localparam logic [15:0] RES_MASK =
        16'(~((32'd1 << (16 - RES_BITS)) - 32'd1));
    localparam int WW = $bits(dar_word_t);

    typedef struct packed {
        logic [2:0]  p1;
        logic [2:0]  p2;
        logic [1:0]  m1;
        logic [1:0]  m2;
        logic        cv_d;
        logic        rd_d;
        logic [15:0] cfg;
        logic [15:0] ref1;
        logic [15:0] ref2;
        logic [15:0] seq;
        logic [15:0] cm;
        logic [3:0]  act;
        logic [3:0]  stg;
        dar_tgt_t    wr_tgt;
        dar_tgt_t    rd_tgt;
        logic        in_act;
        logic [4:0]  in_cnt;
        logic [15:0] in_sh;
        logic [39:0] sha;
        logic [19:0] shb;
        logic [5:0]  out_cnt;
        logic        phase;
        logic        drain;
        logic        rb_after;
        logic        b_off;
        logic        ch;
        logic [1:0]  step;
        logic [1:0]  mux;
        dar_word_t   last;
        dar_word_t   prev;
        logic        conv;
        logic        rdy;
    } dar_top_st_t;

    dar_top_st_t st;
    dar_top_st_t next_st;

    logic        cv_rise;
    logic        rd_rise;
    logic        si;
    logic        m_low;
    logic        m_high;
    logic        f_fe;
    logic        f_sr;
    logic        f_pde;
    logic        f_cid;
    logic        single;
    logic        special;
    logic        buf_ok;
    logic        delay_rd;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    dar_word_t   fifo_out;
    dar_word_t   cur;
    logic [15:0] w;
    logic [15:0] rb_val;

    // Builds one 20-bit frame; the low result bits are blanked per resolution.
    function automatic logic [19:0] frame(input logic i1, input logic i2,
                                          input logic [15:0] d,
                                          input logic no_info);
        logic [15:0] m;
        m = d & RES_MASK;
        frame = no_info ? {m, 4'h0} : {i1, i2, m, 2'h0};
    endfunction

    function automatic logic [1:0] seq_pick(input logic [15:0] s,
                                            input logic [1:0] n);
        logic [1:0] r;
        r = 2'h0;
        unique case (n)
            2'h0: r = s[11:10];
            2'h1: r = s[9:8];
            2'h2: r = s[7:6];
            2'h3: r = s[5:4];
        endcase
        seq_pick = r;
    endfunction

    dar_fifo #(
        .W (WW),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (WW'({st.ch, result.a, result.b})),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out)
    );

    assign cv_rise = st.p2[2] && !st.cv_d;
    assign rd_rise = st.p2[1] && !st.rd_d;
    assign si      = st.p2[0];
    assign m_low   = st.m2[0];
    assign m_high  = st.m2[1];
    assign f_fe    = st.act[3];
    assign f_sr    = st.act[2];
    assign f_pde   = st.act[1];
    assign f_cid   = st.act[0] || st.act[1];
    assign single  = m_low && m_high;
    assign special = single && f_sr;
    // Buffer serves two-line auto and special reads only.
    assign buf_ok  = f_fe && ((m_low && !m_high) || special);
    assign delay_rd = special && st.cfg[CFG_PD+:2] == PD_AUTO;
    assign fifo_in_valid = result.valid && buf_ok;
    assign w = {st.in_sh[14:0], si};

    assign result_ready      = st.rdy;
    assign conv_start        = st.conv;
    assign mux_select        = st.mux;
    assign serial_out_a      = st.sha[39];
    assign serial_out_b      = st.shb[19];
    assign serial_out_b_oe_n = st.b_off;
    assign reference_level_one = st.ref1;
    assign reference_level_two = st.ref2;
    assign power_mode        = st.cfg[CFG_PD+:2];

    always_comb begin
        unique case (st.rd_tgt)
            DAR_TGT_CFG:  rb_val = st.cfg;
            DAR_TGT_REF1: rb_val = st.ref1;
            DAR_TGT_REF2: rb_val = st.ref2;
            DAR_TGT_SEQ:  rb_val = st.seq;
            DAR_TGT_CM:   rb_val = st.cm;
            default:      rb_val = 16'h0000;
        endcase
    end

    always_comb begin
        next_st = st;
        fifo_out_ready = 1'b0;
        cur = delay_rd ? st.prev : st.last;
        next_st.p1 = {conversion_trigger, read_strobe, serial_in};
        next_st.p2 = st.p1;
        next_st.m1 = {mode_select_high, mode_select_low};
        next_st.m2 = st.m1;
        next_st.cv_d = st.p2[2];
        next_st.rd_d = st.p2[1];
        next_st.conv = cv_rise;
        next_st.rdy = !buf_ok || fifo_in_ready;

        // Flag staging: single-line mode picks up new bits one read late.
        if (!single) begin
            next_st.act = {st.cfg[CFG_FE], st.cfg[CFG_SR],
                           st.cfg[CFG_PDE], st.cfg[CFG_CID]};
        end else begin
            if (rd_rise) begin
                next_st.stg = {st.cfg[CFG_FE], st.cfg[CFG_SR],
                               st.cfg[CFG_PDE], st.cfg[CFG_CID]};
            end
            if (cv_rise) begin
                next_st.act = st.stg;
            end
        end

        // Channel stepping at each conversion start.
        if (cv_rise) begin
            next_st.b_off = m_high;
            if (!m_low) begin
                next_st.mux = f_pde ? st.cfg[CFG_C+:2]
                                    : {1'b0, st.cfg[CFG_C+1]};
                next_st.ch = st.cfg[CFG_C+1];
            end else if (f_pde) begin
                next_st.mux = seq_pick(st.seq, st.step);
                next_st.step = st.step + 2'h1;
                next_st.ch = 1'b0;
            end else begin
                next_st.ch = !st.ch;
                next_st.mux = {1'b0, !st.ch};
            end
        end
        if (!m_high) begin
            next_st.b_off = 1'b0;
        end

        // Unbuffered results are held; the older one serves delayed reads.
        if (result.valid && !buf_ok) begin
            next_st.last = {st.ch, result.a, result.b};
            next_st.prev = st.last;
        end

        // Output shifter.
        if (st.out_cnt != 6'h0) begin
            next_st.sha = {st.sha[38:0], 1'b0};
            next_st.shb = {st.shb[18:0], 1'b0};
            next_st.out_cnt = st.out_cnt - 6'h1;
        end

        // Next buffered word, or a readback waiting behind the buffer.
        if (st.drain && st.out_cnt == 6'h1) begin
            if (fifo_out_valid) begin
                fifo_out_ready = 1'b1;
                // Only a special read puts B behind A on out_a; otherwise the
                // tail stays zero so the line idles low after the last frame.
                next_st.sha = {frame(fifo_out.ch, 1'b0, fifo_out.a, f_cid),
                               special ? frame(fifo_out.ch, 1'b1,
                                               fifo_out.b, f_cid)
                                       : 20'h0};
                next_st.shb = frame(fifo_out.ch, 1'b0, fifo_out.b, f_cid);
                next_st.out_cnt = special ? 6'(PAIR_BITS) : 6'(FRAME_BITS);
            end else begin
                next_st.drain = 1'b0;
                if (st.rb_after) begin
                    next_st.rb_after = 1'b0;
                    next_st.rd_tgt = DAR_TGT_NONE;
                    next_st.sha = {frame(st.ch, 1'b0, rb_val, f_cid),
                                   20'h0};
                    next_st.shb = 20'h0;
                    next_st.out_cnt = 6'(FRAME_BITS);
                end
            end
        end

        // A read strobe starts an output frame and, with no readback pending, a 16-bit input word.
        if (rd_rise) begin
            next_st.in_act = st.rd_tgt == DAR_TGT_NONE;
            next_st.in_cnt = 5'h0;
            if (buf_ok && fifo_out_valid) begin
                fifo_out_ready = 1'b1;
                next_st.drain = 1'b1;
                next_st.rb_after = st.rd_tgt != DAR_TGT_NONE;
                next_st.sha = {frame(fifo_out.ch, 1'b0, fifo_out.a, f_cid),
                               special ? frame(fifo_out.ch, 1'b1,
                                               fifo_out.b, f_cid)
                                       : 20'h0};
                next_st.shb = frame(fifo_out.ch, 1'b0, fifo_out.b, f_cid);
                next_st.out_cnt = special ? 6'(PAIR_BITS) : 6'(FRAME_BITS);
            end else if (st.rd_tgt != DAR_TGT_NONE) begin
                // The A result of this read is dropped in favour of the register.
                next_st.rd_tgt = DAR_TGT_NONE;
                next_st.sha = {frame(st.ch, 1'b0, rb_val, f_cid),
                               20'h0};
                next_st.shb = frame(cur.ch, 1'b0, cur.b, f_cid);
                next_st.out_cnt = 6'(FRAME_BITS);
            end else if (special) begin
                next_st.sha = {frame(cur.ch, 1'b0, cur.a, f_cid),
                               frame(cur.ch, 1'b1, cur.b, f_cid)};
                next_st.shb = 20'h0;
                next_st.out_cnt = 6'(PAIR_BITS);
            end else if (single) begin
                // Alternate strobes carry the A frame, then the B frame.
                next_st.phase = !st.phase;
                next_st.sha = {frame(cur.ch, st.phase,
                                     st.phase ? cur.b : cur.a, f_cid),
                               20'h0};
                next_st.shb = 20'h0;
                next_st.out_cnt = 6'(FRAME_BITS);
            end else begin
                next_st.sha = {frame(cur.ch, 1'b0, cur.a, f_cid),
                               20'h0};
                next_st.shb = frame(cur.ch, 1'b0, cur.b, f_cid);
                next_st.out_cnt = 6'(FRAME_BITS);
            end
        end

        // Serial input word capture, MSB first.
        if (st.in_act && !rd_rise) begin
            next_st.in_sh = w;
            next_st.in_cnt = st.in_cnt + 5'h1;
            if (st.in_cnt == 5'(WORD_BITS - 1)) begin
                next_st.in_act = 1'b0;
                // Committed on the edge right after the sixteenth bit.
                unique case (st.wr_tgt)
                    DAR_TGT_REF1: next_st.ref1 = w & REF_MASK;
                    DAR_TGT_REF2: next_st.ref2 = w & REF_MASK;
                    DAR_TGT_SEQ:  next_st.seq = w;
                    DAR_TGT_CM:   next_st.cm = w;
                    default: begin
                        if (w[CFG_R+:2] == UPD_WHOLE) begin
                            next_st.cfg = w;
                            if (w[3:0] == ACC_SWRST) begin
                                next_st.cfg = CFG_RESET;
                                next_st.ref1 = REF_RESET;
                                next_st.ref2 = REF_RESET;
                                next_st.seq = SEQ_RESET;
                                next_st.cm = CM_RESET;
                                next_st.rd_tgt = DAR_TGT_NONE;
                            end else if (w[2:0] == ACC_WR_REF1) begin
                                next_st.wr_tgt = DAR_TGT_REF1;
                            end else if (w[2:0] == ACC_WR_REF2) begin
                                next_st.wr_tgt = DAR_TGT_REF2;
                            end else if (w[3:0] == ACC_WR_SEQ) begin
                                next_st.wr_tgt = DAR_TGT_SEQ;
                            end else if (w[3:0] == ACC_WR_CM) begin
                                next_st.wr_tgt = DAR_TGT_CM;
                            end else if (w[3:0] == ACC_RD_CFG) begin
                                next_st.rd_tgt = DAR_TGT_CFG;
                            end else if (w[3:0] == ACC_RD_REF1) begin
                                next_st.rd_tgt = DAR_TGT_REF1;
                            end else if (w[3:0] == ACC_RD_REF2) begin
                                next_st.rd_tgt = DAR_TGT_REF2;
                            end else if (w[3:0] == ACC_RD_SEQ) begin
                                next_st.rd_tgt = DAR_TGT_SEQ;
                            end else if (w[3:0] == ACC_RD_CM) begin
                                next_st.rd_tgt = DAR_TGT_CM;
                            end
                        end else if ((w[CFG_R+:2] == UPD_SEL_A ||
                                      w[CFG_R+:2] == UPD_SEL_B) &&
                                     !m_low) begin
                            next_st.cfg[CFG_C+:2] = w[CFG_C+:2];
                        end
                    end
                endcase
                if (st.wr_tgt != DAR_TGT_NONE) begin
                    next_st.wr_tgt = DAR_TGT_NONE;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.cfg <= CFG_RESET;
            st.ref1 <= REF_RESET;
            st.ref2 <= REF_RESET;
            st.seq <= SEQ_RESET;
            st.cm <= CM_RESET;
            st.wr_tgt <= DAR_TGT_NONE;
            st.rd_tgt <= DAR_TGT_NONE;
            st.rdy <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
endmodule

`default_nettype wire

// file: dar_sva.sv
// Concurrent checks on the ports of the serial readout block.
`timescale 1ns/1ns
`default_nettype none
module dar_sva (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        conversion_trigger,
    input wire logic        read_strobe,
    input wire logic        mode_select_high,
    input wire logic        result_ready,
    input wire logic        conv_start,
    input wire logic [1:0]  mux_select,
    input wire logic        serial_out_a,
    input wire logic        serial_out_b,
    input wire logic        serial_out_b_oe_n,
    input wire logic [15:0] reference_level_one,
    input wire logic [15:0] reference_level_two,
    input wire logic [1:0]  power_mode
);
    logic [8:0] quiet;
    // A full two-line buffered drain lasts about 330 clocks, hence the wide counter.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            quiet <= 9'h0;
        else if (read_strobe)
            quiet <= 9'h0;
        else if (quiet != 9'h1ff)
            quiet <= quiet + 9'h1;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    ref_reset_a: assert property (
        $rose(nrst) |-> reference_level_one == 16'h07ff
        && reference_level_two == 16'h07ff && power_mode == 2'h0
        && result_ready) else $error("reset values wrong");
    ref_mask_a: assert property (
        reference_level_one[15:11] == 5'h0
        && reference_level_two[15:11] == 5'h0) else $error("ref top bits");
    quiet_regs_a: assert property (
        quiet > 9'd24 |-> $stable(reference_level_one)
        && $stable(reference_level_two) && $stable(power_mode))
        else $error("register changed without a word");
    idle_out_a: assert property (
        quiet > 9'd400 |-> !serial_out_a && !serial_out_b)
        else $error("output busy while idle");
    oe_low_a: assert property (
        !mode_select_high [*6] |-> !serial_out_b_oe_n)
        else $error("out b floats in two-line mode");
    conv_cause_a: assert property (
        conv_start |-> $past(conversion_trigger, 2)
        || $past(conversion_trigger, 3) || $past(conversion_trigger, 4))
        else $error("start without trigger");
    conv_pulse_a: assert property (
        conv_start |=> !conv_start) else $error("start pulse too long");
    mux_hold_a: assert property (
        !$stable(mux_select) |-> conv_start || $past(conv_start))
        else $error("mux moved outside a start");
endmodule
`default_nettype wire

// file: dar_conv_model.sv
// Converter stand-in that answers each conversion start with a result.
`timescale 1ns/1ns
`default_nettype none
module dar_conv_model
    import dar_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        conv_start,
    input  wire logic [15:0] next_a,
    input  wire logic [15:0] next_b,
    output dar_pkg::dar_result_t result
);
    logic [3:0] busy;
    initial begin
        busy = 4'h0;
        result = '0;
    end
    // Words outside the valid pulse are inverted so no stale value passes.
    always @(posedge clk) begin
        busy <= {busy[2:0], conv_start};
        result.valid <= busy[3];
        result.a <= busy[3] ? next_a : ~result.a;
        result.b <= busy[3] ? next_b : ~result.b;
    end
endmodule
`default_nettype wire

// file: tb_dar_serial_regs.sv
// Self-checking bench for the serial readout block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  err_total++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_dar_serial_regs;
    import dar_pkg::*;
    logic         clk = 0, nrst = 0, trig = 0, strb = 0, sin = 0;
    logic         msl = 0, msh = 0, rdy, cst, soa, sob, oen;
    logic [1:0]   mux, pwr, ch;
    logic [15:0]  ref1, ref2, na = 0, nb = 0, w;
    logic [15:0]  e [2];
    logic [319:0] sa;
    logic [19:0]  sb;
    dar_result_t  res;
    int           err_total = 0, comparisons = 0, cyc = 0, n;
    logic [15:0]  q [$];
    dar_serial_regs dut (.clk, .nrst, .conversion_trigger(trig),
        .read_strobe(strb), .serial_in(sin), .mode_select_low(msl),
        .mode_select_high(msh), .result(res), .result_ready(rdy),
        .conv_start(cst), .mux_select(mux), .serial_out_a(soa),
        .serial_out_b(sob), .serial_out_b_oe_n(oen),
        .reference_level_one(ref1), .reference_level_two(ref2),
        .power_mode(pwr));
    dar_conv_model conv_m (.clk, .conv_start(cst), .next_a(na),
        .next_b(nb), .result(res));
    initial forever #2 clk = ~clk;
    task automatic end_sim();
        $display("checks %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end
    // One-clock strobe, word MSB first, then a 40-clock access at least.
    task automatic xfer(input logic [15:0] wd, input int nbit);
        @(posedge clk) #1 strb = 1;
        @(posedge clk) #1 strb = 0;
        sin = wd[15];
        for (int c = 1; c < nbit + 24; c++) begin
            @(posedge clk) #1;
            if (c >= 2 && c < nbit + 2) sa = {sa[318:0], soa};
            if (c >= 2 && c < 22) sb = {sb[18:0], sob};
            sin = c < 16 ? wd[15 - c] : 1'b0;
        end
    endtask
    task automatic conv();
        na = 16'($urandom);
        nb = 16'($urandom);
        @(posedge clk) #1 trig = 1;
        @(posedge clk) #1 trig = 0;
        repeat (12) @(posedge clk);
        #1;
    endtask
    initial begin
        void'($urandom(32'hd478));
        repeat (3) @(posedge clk);
        #1 nrst = 1;
        `CHK("ref1", 16'h07ff, ref1)
        `CHK("ref2", 16'h07ff, ref2)
        for (int k = 0; k < 2; k++) begin
            w = 16'($urandom);
            e[k] = w & 16'h07ff;
            xfer(k ? 16'h1005 : 16'h1002, 20);
            xfer(w, 20);
            `CHK("ref", e[k], k ? ref2 : ref1)
        end
        xfer(16'h1003, 20);
        xfer(16'h1002, 20);
        `CHK("readback one", {2'h0, e[0], 2'h0}, sa[19:0])
        xfer(16'h0155, 20);
        `CHK("ref1 kept", e[0], ref1)
        xfer(16'h1026, 20);
        xfer(16'h0000, 20);
        `CHK("readback two", {e[1], 4'h0}, sa[19:0])
        xfer(16'h1004, 20);
        `CHK("soft reset", 16'h07ff, ref2)
        msl = 1;
        xfer(16'h1000, 20);
        for (int k = 0; k < 2; k++) begin
            conv();
            xfer(16'h0000, 20);
            ch[k] = sa[19];
            `CHK("two a", {ch[k], 1'b0, na, 2'h0}, sa[19:0])
            `CHK("two b", {ch[k], 1'b0, nb, 2'h0}, sb)
            `CHK("mux", {1'b0, ch[k]}, mux)
        end
        `CHK("pair step", ~ch[0], ch[1])
        xfer(16'h1040, 20);
        conv();
        xfer(16'h0000, 20);
        `CHK("pseudo a", {na, 4'h0}, sa[19:0])
        xfer(16'h1000, 20);
        msh = 1;
        conv();
        `CHK("b floats", 1'b1, oen)
        xfer(16'h0000, 20);
        `CHK("single a", {sa[19], 1'b0, na, 2'h0}, sa[19:0])
        xfer(16'h0000, 20);
        `CHK("single b", {sa[19], 1'b1, nb, 2'h0}, sa[19:0])
        xfer(16'h1100, 20);
        xfer(16'h0000, 20);
        conv();
        xfer(16'h0000, 40);
        `CHK("special a", {sa[39], 1'b0, na, 2'h0}, sa[39:20])
        `CHK("special b", {sa[39], 1'b1, nb, 2'h0}, sa[19:0])
        w = na;
        xfer(16'h1d00, 40);
        `CHK("power", 2'h3, pwr)
        conv();
        xfer(16'h0000, 40);
        `CHK("late a", w, sa[37:22])
        msh = 0;
        xfer(16'h1200, 20);
        for (n = 0; n < 20 && rdy === 1'b1; n++) begin
            conv();
            q.push_back(na);
        end
        `CHK("depth", 16, n)
        xfer(16'h0000, 320);
        for (int k = 0; k < 16; k++) begin
            n = 319 - 20 * k;
            `CHK("buffer a", {sa[n], 1'b0, q[k], 2'h0}, sa[n -: 20])
        end
        `CHK("drained", 1'b1, rdy)
        end_sim();
    end
endmodule
bind dar_serial_regs dar_sva chk (.clk, .nrst, .conversion_trigger,
    .read_strobe, .mode_select_high, .result_ready, .conv_start,
    .mux_select, .serial_out_a, .serial_out_b, .serial_out_b_oe_n,
    .reference_level_one, .reference_level_two, .power_mode);
`default_nettype wire
